/* verilog/port_a_pkg.sv */
package port_a_pkg;

    // register indices; byte address is index times four
    localparam int          ADDR_W             = 18;
    localparam int          DATA_W             = 32;
    localparam int          PORT_W             = 8;
    localparam logic [15:0] DIRECTION_INDEX    = 16'hffd1;
    localparam logic [15:0] OUTPUT_LATCH_INDEX = 16'hffd3;
    localparam logic [15:0] PIN_STATUS_INDEX   = 16'hffd5;

    // values after reset or hardware standby, and the fixed direction read value
    localparam logic [7:0]  DIRECTION_RESET_PLAIN = 8'h00;
    localparam logic [7:0]  DIRECTION_RESET_ADDR  = 8'h80;
    localparam logic [7:0]  LATCH_RESET           = 8'h00;
    localparam logic [7:0]  DIRECTION_READ_VALUE  = 8'hff;
    localparam logic [2:0]  MODE_RESET            = 3'h7;

    // field positions
    localparam int          PIN7_POS           = 7;
    localparam int          STATUS_FN_LSB      = 0;
    localparam int          STATUS_CAPTURE_BIT = 5;
    localparam int          STATUS_STANDBY_BIT = 6;

    // operating modes in which pin 7 carries the upper address bit
    localparam logic [2:0]  MODE_ADDR_A = 3'h3;
    localparam logic [2:0]  MODE_ADDR_B = 3'h4;
    localparam logic [2:0]  MODE_ADDR_C = 3'h6;

    // io select codes that mean compare output
    localparam logic [2:0]  IO_SEL_COMPARE_MIN = 3'h1;
    localparam logic [2:0]  IO_SEL_COMPARE_MAX = 3'h3;

    localparam int          SYNC_STAGES = 3;

    // function currently owning pin 7
    typedef enum logic [4:0] {
        FN_INPUT   = 5'h01,
        FN_LATCH   = 5'h02,
        FN_PATTERN = 5'h04,
        FN_TIMER   = 5'h08,
        FN_ADDR    = 5'h10
    } pin7_fn_t;

    function automatic logic is_addr_mode(input logic [2:0] mode);
        is_addr_mode = (mode == MODE_ADDR_A) || (mode == MODE_ADDR_B) || (mode == MODE_ADDR_C);
    endfunction : is_addr_mode

    function automatic logic [7:0] direction_reset(input logic [2:0] mode);
        direction_reset = is_addr_mode(mode) ? DIRECTION_RESET_ADDR : DIRECTION_RESET_PLAIN;
    endfunction : direction_reset

    function automatic logic is_compare(input logic [2:0] sel);
        is_compare = (sel >= IO_SEL_COMPARE_MIN) && (sel <= IO_SEL_COMPARE_MAX);
    endfunction : is_compare

endpackage : port_a_pkg

/* verilog/pin_sync.sv */
`timescale 1ns/1ns

module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             rst_i,   // async reset, active high
    input  wire logic [WIDTH-1:0] pins_i,  // raw pad levels
    output logic      [WIDTH-1:0] level_o  // settled pin levels
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    // three stage chain; only the second stage reads the first
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit changes once stages two and three agree, so glitches die
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_q <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level_o = level_q;

endmodule : pin_sync

/* verilog/pin7_mux.sv */
`timescale 1ns/1ns

module pin7_mux (
    input  wire logic             addr_mode_i,     // mode puts address bit on pin 7
    input  wire logic [2:0]       io_select_i,     // channel 2 b io select field
    input  wire logic             pwm_select_i,    // channel 2 pwm select
    input  wire logic             direction_bit_i, // stored direction bit of pin 7
    input  wire logic             pattern_en_i,    // pattern enable for pin 7
    input  wire logic             latch_i,         // latch bit 7
    input  wire logic             pattern_i,       // pattern output 7
    input  wire logic             compare_i,       // timer compare output level
    input  wire logic             upper_addr_i,    // upper address bit
    output port_a_pkg::pin7_fn_t  fn_o,            // owning function
    output logic                  drive_o,         // pin 7 driven
    output logic                  level_o,         // level when driven
    output logic                  capture_en_o     // pin feeds timer capture
);

    // priority: address, compare, direction, pattern enable
    always_comb begin
        if (addr_mode_i) begin
            fn_o = port_a_pkg::FN_ADDR; // [R5]
        end else if (port_a_pkg::is_compare(io_select_i)) begin
            fn_o = port_a_pkg::FN_TIMER; // [R9] [R10]
        end else if (!direction_bit_i) begin
            fn_o = port_a_pkg::FN_INPUT; // [R11]
        end else if (pattern_en_i) begin
            fn_o = port_a_pkg::FN_PATTERN; // [R11] [R8]
        end else begin
            fn_o = port_a_pkg::FN_LATCH; // [R11]
        end
    end

    // output level for each owner
    always_comb begin
        drive_o = 1'b1;
        unique case (fn_o)
            port_a_pkg::FN_ADDR:    level_o = upper_addr_i;
            port_a_pkg::FN_TIMER:   level_o = compare_i;
            port_a_pkg::FN_PATTERN: level_o = pattern_i;
            port_a_pkg::FN_LATCH:   level_o = latch_i;
            port_a_pkg::FN_INPUT: begin
                level_o = 1'b0;
                drive_o = 1'b0;
            end
            default: begin
                level_o = 1'b0;
                drive_o = 1'b0;
            end
        endcase
    end

    // capture path is independent of who drives the pin
    assign capture_en_o = io_select_i[2] & ~pwm_select_i;           // [R12]

endmodule : pin7_mux

/* verilog/port_a_gpio.sv */
// Function
// R1 - Direction bit one makes a pin an output, zero an input.
// R2 - Direction is write-only and reads back as all ones.
// R3 - Reset or hardware standby load direction 00, or 80 in modes 3, 4 and 6.
// R4 - Software standby keeps direction and output pins keep driving.
// R5 - In modes 3, 4 and 6 pin 7 is a fixed output of address bit 20.
// R6 - Data reads give the latch for output pins and the pin level for inputs.
// R7 - The latch clears on reset or hardware standby and holds in software standby.
// R8 - Pattern output needs its direction bit set by software.
// R9 - Outside address modes the channel 2 B compare output owns pin 7 first.
// R10 - Compare output means io select 001, 010 or 011.
// R11 - Else pin 7 is input at direction zero, else latch or pattern by pattern enable.
// R12 - Pin 7 feeds capture when io select high is one and pwm select is zero.
// R13 - A latch write stores the bit even for input pins.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns

module port_a_gpio (
    input  wire logic                            clk_i,                          // system clock
    input  wire logic                            rst_i,                          // async reset
    // avalon-mm slave
    input  wire logic [port_a_pkg::ADDR_W-1:0]   address_i,                      // byte address
    input  wire logic                            read_i,                         // read request
    input  wire logic                            write_i,                        // write request
    input  wire logic [port_a_pkg::DATA_W-1:0]   writedata_i,                    // write data
    input  wire logic [3:0]                      byteenable_i,                   // byte lanes
    output logic      [port_a_pkg::DATA_W-1:0]   readdata_o,                     // read data
    output logic                                 waitrequest_o,                  // stall
    // chip state
    input  wire logic [2:0]                      mode_i,                         // operating mode
    input  wire logic                            hw_standby_i,                   // hardware standby
    input  wire logic                            sw_standby_i,                   // software standby
    // timer channel 2 b
    input  wire logic                            channel2_b_io_select_high_i,    // io select bit 2
    input  wire logic                            channel2_b_io_select_mid_i,     // io select bit 1
    input  wire logic                            channel2_b_io_select_low_i,     // io select bit 0
    input  wire logic                            channel2_pwm_select_i,          // pwm mode
    input  wire logic                            timer_ch2_b_compare_i,          // compare level
    output logic                                 timer_ch2_b_capture_o,          // capture level
    // pattern unit and bus controller
    input  wire logic                            pin7_pattern_output_enable_i,   // pattern enable 7
    input  wire logic                            pattern_output_7_i,             // pattern level 7
    input  wire logic                            upper_address_bit_i,            // address bit 20
    // pads
    input  wire logic [port_a_pkg::PORT_W-1:0]   port_pins_i,                    // pad levels
    output logic      [port_a_pkg::PORT_W-1:0]   port_pins_o,                    // pad drive level
    output logic      [port_a_pkg::PORT_W-1:0]   port_pins_oe_o                  // pad drive enable
);

    localparam int W = port_a_pkg::PORT_W;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                  init_q;
    logic [2:0]            mode_q;
    logic                  addr_mode;
    logic                  load_reset;
    logic [W-1:0]          direction_q;
    logic [W-1:0]          direction_eff;
    logic [W-1:0]          latch_q;
    logic [W-1:0]          pin_level;
    logic                  ack_q;
    logic                  waitrequest_q;
    logic [31:0]           readdata_q;
    logic                  request;
    logic                  write_take;
    logic                  lane0;
    logic [15:0]           reg_index;
    logic                  hit_direction;
    logic                  hit_latch;
    logic                  hit_status;
    logic [W-1:0]          read_value;
    logic [W-1:0]          status_value;
    logic [2:0]            io_select;
    port_a_pkg::pin7_fn_t  pin7_fn;
    port_a_pkg::pin7_fn_t  pin7_fn_q;
    logic                  pin7_drive;
    logic                  pin7_level;
    logic                  capture_en;
    logic                  capture_en_q;
    logic [W-1:0]          pins_q;
    logic [W-1:0]          pins_oe_q;
    logic                  capture_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // mode strap and reset loading

    // mode is caught at the first clock after reset release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    // hardware standby also resamples the mode
    assign load_reset = init_q | hw_standby_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= port_a_pkg::MODE_RESET;
        end else if (load_reset) begin
            mode_q <= mode_i;
        end
    end

    assign addr_mode = port_a_pkg::is_addr_mode(mode_q);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave

    assign request   = (read_i | write_i) & ~ack_q;
    assign lane0     = byteenable_i[0];
    assign reg_index = address_i[port_a_pkg::ADDR_W-1:2];

    // low two address bits are ignored
    assign hit_direction = (reg_index == port_a_pkg::DIRECTION_INDEX);
    assign hit_latch     = (reg_index == port_a_pkg::OUTPUT_LATCH_INDEX);
    assign hit_status    = (reg_index == port_a_pkg::PIN_STATUS_INDEX);

    // a write lands on the edge where the master sees waitrequest low
    assign write_take = write_i & ack_q & lane0;

    // one wait state: a request is acknowledged one cycle after it appears
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q         <= 1'b0;
            waitrequest_q <= 1'b1;
        end else begin
            ack_q         <= request;
            waitrequest_q <= ~request;
        end
    end

    // status: pin 7 owner, capture enable and standby
    always_comb begin
        status_value = '0;
        status_value[port_a_pkg::STATUS_FN_LSB +: 5]    = pin7_fn_q;
        status_value[port_a_pkg::STATUS_CAPTURE_BIT]    = capture_en_q;
        status_value[port_a_pkg::STATUS_STANDBY_BIT]    = sw_standby_i;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        read_value = '0;
        if (hit_direction) begin
            read_value = port_a_pkg::DIRECTION_READ_VALUE; // [R2]
        end else if (hit_latch) begin
            for (int i = 0; i < W; i++) begin
                read_value[i] = direction_eff[i] ? latch_q[i] : pin_level[i];     // [R6]
            end
        end else if (hit_status) begin
            read_value = status_value;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_q <= '0;
        end else if (request & read_i) begin
            readdata_q <= {24'h000000, read_value};
        end
    end

    assign readdata_o    = readdata_q;
    assign waitrequest_o = waitrequest_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // direction register

    // only reset or hardware standby reload it; software standby keeps it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_q <= port_a_pkg::DIRECTION_RESET_PLAIN;
        end else if (load_reset) begin
            direction_q <= port_a_pkg::direction_reset(mode_i); // [R3]
        end else if (write_take & hit_direction) begin
            direction_q <= writedata_i[W-1:0];
            if (addr_mode) begin
                direction_q[port_a_pkg::PIN7_POS] <= 1'b1; // [R5]
            end
        end
    end

    // pin 7 direction is forced in address modes regardless of the stored bit
    always_comb begin
        direction_eff = direction_q;
        if (addr_mode) begin
            direction_eff[port_a_pkg::PIN7_POS] = 1'b1; // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // output latch

    // input pins still store writes, ready for when they turn around
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_q <= port_a_pkg::LATCH_RESET;
        end else if (hw_standby_i) begin
            latch_q <= port_a_pkg::LATCH_RESET; // [R7]
        end else if (write_take & hit_latch) begin
            latch_q <= writedata_i[W-1:0]; // [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // pin input path

    pin_sync #(
        .WIDTH   (W)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pins_i  (port_pins_i),
        .level_o (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // pin 7 function select

    assign io_select = {channel2_b_io_select_high_i,
                        channel2_b_io_select_mid_i,
                        channel2_b_io_select_low_i};

    pin7_mux u_pin7_mux (
        .addr_mode_i     (addr_mode),
        .io_select_i     (io_select),
        .pwm_select_i    (channel2_pwm_select_i),
        .direction_bit_i (direction_q[port_a_pkg::PIN7_POS]),
        .pattern_en_i    (pin7_pattern_output_enable_i),
        .latch_i         (latch_q[port_a_pkg::PIN7_POS]),
        .pattern_i       (pattern_output_7_i),
        .compare_i       (timer_ch2_b_compare_i),
        .upper_addr_i    (upper_address_bit_i),
        .fn_o            (pin7_fn),
        .drive_o         (pin7_drive),
        .level_o         (pin7_level),
        .capture_en_o    (capture_en)
    );

    // owner registered so software sees a stable value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin7_fn_q    <= port_a_pkg::FN_INPUT;
            capture_en_q <= 1'b0;
        end else begin
            pin7_fn_q    <= pin7_fn;
            capture_en_q <= capture_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // pad drive

    // pins 6..0 follow direction and latch; pin 7 follows its selector
    // pads freeze in software standby
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_q    <= '0;
            pins_oe_q <= '0;
        end else if (!sw_standby_i) begin // [R4]
            for (int i = 0; i < W; i++) begin
                if (i == port_a_pkg::PIN7_POS) begin
                    pins_oe_q[i] <= pin7_drive; // [R9] [R11]
                    pins_q[i]    <= pin7_level; // [R5]
                end else begin
                    pins_oe_q[i] <= direction_q[i]; // [R1]
                    pins_q[i]    <= direction_q[i] & latch_q[i]; // [R1]
                end
            end
        end
    end

    assign port_pins_o    = pins_q;
    assign port_pins_oe_o = pins_oe_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // capture feed

    // the timer sees zero while the capture path is off, so stray pin edges cannot trigger it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            capture_q <= 1'b0;
        end else begin
            capture_q <= capture_en & pin_level[port_a_pkg::PIN7_POS];            // [R12]
        end
    end

    assign timer_ch2_b_capture_o = capture_q;

endmodule : port_a_gpio

/* tb/port_a_monitor.sv */
`timescale 1ns/1ns

module port_a_monitor (
    input wire logic        clk_i,                       // clock
    input wire logic        rst_i,                       // reset
    input wire logic [17:0] address_i,                   // byte address
    input wire logic        read_i,                      // read
    input wire logic        write_i,                     // write
    input wire logic [31:0] readdata_o,                  // read data
    input wire logic        waitrequest_o,               // stall
    input wire logic [2:0]  mode_i,                      // mode
    input wire logic        hw_standby_i,                // hw standby
    input wire logic        sw_standby_i,                // sw standby
    input wire logic        channel2_b_io_select_high_i, // sel 2
    input wire logic        channel2_b_io_select_mid_i,  // sel 1
    input wire logic        channel2_b_io_select_low_i,  // sel 0
    input wire logic        channel2_pwm_select_i,       // pwm
    input wire logic        timer_ch2_b_compare_i,       // compare
    input wire logic        timer_ch2_b_capture_o,       // capture
    input wire logic        upper_address_bit_i,         // address bit
    input wire logic [7:0]  port_pins_i,                 // pad level
    input wire logic [7:0]  port_pins_o,                 // pad drive
    input wire logic [7:0]  port_pins_oe_o               // pad enable
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] up_q;
    logic [2:0] sel;
    logic       addr_m;
    logic       ready;
    // pads follow the mode two edges after release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    assign sel    = {channel2_b_io_select_high_i, channel2_b_io_select_mid_i,
                     channel2_b_io_select_low_i};
    assign addr_m = (mode_i == 3'h3) || (mode_i == 3'h4) || (mode_i == 3'h6);
    assign ready  = (up_q == 2'h3) && !hw_standby_i;
    sequence pin7_capture_run;
        (ready && sel[2] && !channel2_pwm_select_i && port_pins_i[7]) [*7];
    endsequence
    wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("long ack");
    ack_bound_a: assert property ((read_i || write_i) && waitrequest_o |-> ##[1:2] !waitrequest_o)
        else $error("no ack");
    dir_ones_a: assert property (read_i && !waitrequest_o &&
        address_i[17:2] == port_a_pkg::DIRECTION_INDEX |-> readdata_o == 32'h000000ff)
        else $error("direction read");
    compare_drive_a: assert property (ready && !addr_m && !sw_standby_i &&
        sel inside {3'h1, 3'h2, 3'h3} |=> port_pins_oe_o[7] &&
        port_pins_o[7] == $past(timer_ch2_b_compare_i)) else $error("compare drive");
    addr_drive_a: assert property (ready && addr_m && !sw_standby_i |=>
        port_pins_oe_o[7] && port_pins_o[7] == $past(upper_address_bit_i))
        else $error("address drive");
    standby_hold_a: assert property (ready && sw_standby_i |=>
        $stable(port_pins_o) && $stable(port_pins_oe_o)) else $error("pads moved");
    capture_on_a: assert property (pin7_capture_run |=> timer_ch2_b_capture_o)
        else $error("capture missing");
    capture_off_a: assert property (ready && !(sel[2] && !channel2_pwm_select_i) |=>
        !timer_ch2_b_capture_o) else $error("capture leak");
    standby_reset_a: assert property (hw_standby_i [*3] |-> port_pins_oe_o[6:0] == 7'h00)
        else $error("standby drive");
endmodule : port_a_monitor

bind port_a_gpio port_a_monitor i_port_a_monitor (.clk_i, .rst_i, .address_i, .read_i,
    .write_i, .readdata_o, .waitrequest_o, .mode_i, .hw_standby_i, .sw_standby_i,
    .channel2_b_io_select_high_i, .channel2_b_io_select_mid_i, .channel2_b_io_select_low_i,
    .channel2_pwm_select_i, .timer_ch2_b_compare_i, .timer_ch2_b_capture_o,
    .upper_address_bit_i, .port_pins_i, .port_pins_o, .port_pins_oe_o);

/* tb/board_model.sv */
`timescale 1ns/1ns

module board_model (
    input  wire logic [7:0] pad_drive_i, // device drive level
    input  wire logic [7:0] pad_oe_i,    // device drive enable
    input  wire logic [7:0] ext_level_i, // board drive level
    output logic      [7:0] wire_o       // resolved pad level
);
    // the board drives every pad the device leaves; a driven pad shows the device
    assign wire_o = (pad_oe_i & pad_drive_i) | (~pad_oe_i & ext_level_i);
endmodule : board_model

/* tb/tb_top.sv */
`timescale 1ns/1ns

module tb_top;
    localparam logic [15:0] DIR = port_a_pkg::DIRECTION_INDEX;
    localparam logic [15:0] LAT = port_a_pkg::OUTPUT_LATCH_INDEX;
    logic        clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0, waitrequest_o;
    logic        hw_stby = 1'b0, sw_stby = 1'b0, pwm = 1'b0, cmp = 1'b0, capture;
    logic        pen = 1'b0, pat = 1'b0, upa = 1'b0;
    logic [2:0]  mode = 3'h1, sel = 3'h0;
    logic [17:0] address_i = 18'h0;
    logic [31:0] writedata_i = 32'h0, readdata_o;
    logic [7:0]  ext_q = 8'h00, pins_in, pins_o, pins_oe, rd;
    int          n_errors = 0, tests_run = 0, cycles = 0;

    always #25 clk_i = ~clk_i;

    port_a_gpio i_port_a_gpio (.clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
        .byteenable_i(4'hf), .readdata_o, .waitrequest_o, .mode_i(mode), .hw_standby_i(hw_stby),
        .sw_standby_i(sw_stby), .channel2_b_io_select_high_i(sel[2]),
        .channel2_b_io_select_mid_i(sel[1]), .channel2_b_io_select_low_i(sel[0]),
        .channel2_pwm_select_i(pwm), .timer_ch2_b_compare_i(cmp), .timer_ch2_b_capture_o(capture),
        .pin7_pattern_output_enable_i(pen), .pattern_output_7_i(pat), .upper_address_bit_i(upa),
        .port_pins_i(pins_in), .port_pins_o(pins_o), .port_pins_oe_o(pins_oe));
    board_model i_board_model (.pad_drive_i(pins_o), .pad_oe_i(pins_oe), .ext_level_i(ext_q),
        .wire_o(pins_in));

    // a hung handshake ends the run here
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk_i);
        address_i <= {idx, 2'b00};
        read_i <= !wr;
        write_i <= wr;
        writedata_i <= {24'h0, wd};
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask : bus

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode <= m;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_plain;
        do_reset(3'h1);
        check("oe after reset", pins_oe, 8'h00);
        bus(1'b0, DIR, 8'h00);
        check("direction read", rd, 8'hff);
        bus(1'b1, DIR, 8'hff);
        repeat (2) @(posedge clk_i);
        check("latch after reset", pins_o, 8'h00);
        bus(1'b1, DIR, 8'h00);
        bus(1'b1, LAT, 8'h5a);
        ext_q <= 8'ha5;
        repeat (6) @(posedge clk_i);
        bus(1'b0, LAT, 8'h00);
        check("input read", rd, 8'ha5);
        bus(1'b1, DIR, 8'h0f);
        repeat (2) @(posedge clk_i);
        check("oe nibble", pins_oe, 8'h0f);
        check("stored while input", pins_o & 8'h0f, 8'h0a);
        bus(1'b0, LAT, 8'h00);
        check("mixed read", rd, 8'haa);
        bus(1'b0, 16'h0000, 8'h00);
        check("unmapped read", rd, 8'h00);
    endtask : t_plain

    task automatic t_pin7;
        bus(1'b1, DIR, 8'h80);
        bus(1'b1, LAT, 8'h00);
        cmp <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            sel <= s[2:0];
            repeat (2) @(posedge clk_i);
            check("owner", {6'h0, pins_oe[7], pins_o[7]},
                  (s >= 1 && s <= 3) ? 8'h3 : 8'h2);
        end
        sel <= 3'h0;
        pen <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("pattern low", {7'h0, pins_o[7]}, 8'h00);
        pat <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("pattern high", {7'h0, pins_o[7]}, 8'h01);
        bus(1'b1, DIR, 8'h00);
        repeat (2) @(posedge clk_i);
        check("pin7 input", {7'h0, pins_oe[7]}, 8'h00);
        sel <= 3'h4;
        ext_q <= 8'h80;
        repeat (9) @(posedge clk_i);
        check("capture fed", {7'h0, capture}, 8'h01);
        pwm <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("capture cut", {7'h0, capture}, 8'h00);
        sel <= 3'h0;
        pen <= 1'b0;
        pwm <= 1'b0;
    endtask : t_pin7

    task automatic t_standby;
        bus(1'b1, DIR, 8'hff);
        bus(1'b1, LAT, 8'h3c);
        @(posedge clk_i);
        sw_stby <= 1'b1;
        bus(1'b1, LAT, 8'hc3);
        repeat (2) @(posedge clk_i);
        check("frozen pads", pins_o, 8'h3c);
        sw_stby <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("latch kept", pins_o, 8'hc3);
        hw_stby <= 1'b1;
        repeat (3) @(posedge clk_i);
        hw_stby <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("standby direction", pins_oe, 8'h00);
        bus(1'b1, DIR, 8'hff);
        repeat (2) @(posedge clk_i);
        check("standby latch", pins_o, 8'h00);
    endtask : t_standby

    task automatic t_addr;
        do_reset(3'h3);
        upa <= 1'b1;
        sel <= 3'h1;
        repeat (2) @(posedge clk_i);
        check("address mode oe", pins_oe, 8'h80);
        check("address bit", {7'h0, pins_o[7]}, 8'h01);
        bus(1'b1, DIR, 8'h00);
        repeat (2) @(posedge clk_i);
        check("pin7 fixed", pins_oe, 8'h80);
    endtask : t_addr

    initial begin
        t_plain();
        t_pin7();
        t_standby();
        t_addr();
        summarize();
    end
endmodule : tb_top
